//--- hdl/acpc_pkg.sv
// Constants, register map and carrier types for the channel phase and calibration block.
// Assumes a 32-bit APB master and one clock that doubles as the modulator clock.
`default_nettype none
package acpc_pkg;
    localparam int NUM_CH      = 4;
    localparam int DATA_W      = 24;
    localparam int PHASE_W     = 10;
    localparam int CNT_W       = 14;
    localparam int ACC_W       = 16;
    localparam int WIDE_W      = 52;
    localparam int FIFO_DEPTH  = 8;
    localparam int UPPER_W     = 16;
    localparam int LOWER_W     = 8;
    localparam int OSR_CODE_W  = 4;
    localparam int CFG_SEL_LSB   = 0;
    localparam int CFG_PHASE_LSB = 6;
    localparam int DATA_CH_LSB   = 24;
    localparam int STAT_CNT_LSB  = 4;
    localparam int STAT_PEND_LSB = 8;
    // Byte addresses
    localparam logic [7:0] ADDR_GLOBAL_CFG = 8'h00;
    localparam logic [7:0] ADDR_STATUS     = 8'h04;
    localparam logic [7:0] ADDR_DATA       = 8'h08;
    // Channel blocks sit at 0x20 * (channel + 1), selected by paddr[7:5]
    localparam logic [2:0] CH_BLOCK_FIRST  = 3'h1;
    localparam logic [2:0] CH_BLOCK_LAST   = 3'h4;
    localparam logic [2:0] CH_REG_CONFIG   = 3'h0;
    localparam logic [2:0] CH_REG_OFF_UP   = 3'h1;
    localparam logic [2:0] CH_REG_OFF_LO   = 3'h2;
    localparam logic [2:0] CH_REG_GAIN_UP  = 3'h3;
    localparam logic [2:0] CH_REG_GAIN_LO  = 3'h4;
    // Oversampling ratio: code 0 is 64, code 8 is 16384
    localparam logic [3:0] OSR_CODE_MAX    = 4'h8;
    localparam logic [3:0] OSR_CODE_RESET  = 4'h4;
    localparam logic [3:0] OSR_CODE_CAP    = 4'h4;
    localparam logic [3:0] OSR_LOG2_MIN    = 4'h6;
    localparam logic [10:0] PHASE_HALF_MIN = 11'h020;
    localparam logic [10:0] PHASE_HALF_CAP = 11'h200;
    // Calibration
    localparam logic [23:0] OFFSET_RESET   = 24'h000000;
    localparam logic [23:0] GAIN_RESET     = 24'h800000;
    localparam logic [4:0]  GAIN_FRAC_BITS = 5'h17;
    localparam logic [23:0] SAT_POS        = 24'h7FFFFF;
    localparam logic [23:0] SAT_NEG        = 24'h800000;
    // Test level density 17/30 ones gives a mean of 2/15 full scale
    localparam logic [4:0]  TEST_STEP      = 5'h11;
    localparam logic [4:0]  TEST_MOD       = 5'h1E;

    typedef enum logic [1:0] {
        ACPC_SEL_NORMAL   = 2'b00,
        ACPC_SEL_SHORT    = 2'b01,
        ACPC_SEL_TEST_POS = 2'b10,
        ACPC_SEL_TEST_NEG = 2'b11
    } acpc_input_sel_t;

    typedef struct packed {
        logic [PHASE_W-1:0] sample_phase_offset;
        acpc_input_sel_t    input_select;
    } acpc_channel_config_t;

    typedef struct packed {
        logic [1:0]        channel;
        logic [DATA_W-1:0] data;
    } acpc_sample_t;
endpackage : acpc_pkg
`default_nettype wire

//--- hdl/acpc_top.sv
// Channel input select, phase-shifted decimation, offset and gain correction, output FIFO.
// Assumes an APB master on ref_clk_in and one-bit modulator streams arriving on pins.
//
// Functional notes
// - Two-bit input_select picks normal input, short (zero), positive or negative test level.
// - One shared test level generator feeds every channel.
// - Test level is a fixed 2/15 of full scale before offset and gain correction.
// - sample_phase_offset is a 10-bit signed count of modulator clocks.
// - Each result spans oversampling_ratio samples; equal phases align windows.
// - Phase range is -ratio/2 to ratio/2-1, capped at -512 to 511.
// - Out-of-range phase is clipped to the nearest limit.
// - Limits per ratio: 64..512 scale, 1024 and above fixed at -512..511.
// - conversion_ready_n timing follows the channel phase settings.
// - Subtract a 24-bit signed offset_coefficient split upper/lower per channel.
// - Multiply by 24-bit unsigned gain_coefficient, 800000h is unity.
// - Correction always applied; defaults leave data unchanged.
// - After reset offset reads 000000h and gain reads 800000h.
// - Reset restores every configuration register to its default.
`default_nettype none

module acpc_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 8
) (
    input  wire logic                       ref_clk_in,
    input  wire logic                       reset_n_in,
    input  wire logic                       in_valid_in,
    output logic                            in_ready_out,
    input  wire logic [WIDTH-1:0]           in_data_in,
    output logic                            out_valid_out,
    input  wire logic                       out_ready_in,
    output logic [WIDTH-1:0]                out_data_out,
    output logic [$clog2(DEPTH+1)-1:0]      count_out
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [CW-1:0]    count_reg;
    logic             push;
    logic             pop;

    assign in_ready_out  = (count_reg != CW'(DEPTH));
    assign out_valid_out = (count_reg != '0);
    assign out_data_out  = mem[rd_ptr_reg];
    assign count_out     = count_reg;
    assign push          = in_valid_in & in_ready_out;
    assign pop           = out_ready_in & out_valid_out;

    always_ff @(posedge ref_clk_in) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + AW'(1);
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + AW'(1);
            end
            if (push && !pop) begin
                count_reg <= count_reg + CW'(1);
            end else if (pop && !push) begin
                count_reg <= count_reg - CW'(1);
            end
        end
    end
endmodule : acpc_fifo

module acpc_top
    import acpc_pkg::*;
#(
    parameter int FIFO_W = 26,
    parameter int FIFO_D = FIFO_DEPTH
) (
    input  wire logic              ref_clk_in,
    input  wire logic              reset_n_in,
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [7:0]        paddr_in,
    input  wire logic [31:0]       pwdata_in,
    output logic [31:0]            prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    input  wire logic [NUM_CH-1:0] mod_bit_in,
    output logic                   conversion_ready_n_out
);
    localparam int CW = $clog2(FIFO_D+1);

    // Configuration state
    logic [OSR_CODE_W-1:0] osr_code_reg;
    acpc_channel_config_t  cfg_reg    [NUM_CH];
    logic [DATA_W-1:0]     offset_reg [NUM_CH];
    logic [DATA_W-1:0]     gain_reg   [NUM_CH];

    // Bus state
    logic        pready_reg;
    logic        pslverr_reg;
    logic [31:0] prdata_reg;
    logic        ready_n_reg;
    logic        access;
    logic        load;
    logic        done;
    logic        hit_cfg;
    logic        hit_stat;
    logic        hit_data;
    logic        hit_ch;
    logic [1:0]  ch_idx;
    logic [2:0]  ch_sel;
    logic        mapped;
    logic [31:0] rd_mux;

    // Data path
    logic [4:0]        test_acc_reg;
    logic              test_bit_reg;
    logic [CNT_W-1:0]  mod_count_reg;
    logic [CNT_W-1:0]  osr_last;
    logic [4:0]        frac_shift;
    logic signed [10:0] phase_hi;
    logic signed [10:0] phase_lo;
    logic [NUM_CH-1:0]  pend_vec;
    logic [NUM_CH-1:0]  push_oh;
    logic [DATA_W-1:0]  res_vec [NUM_CH];
    acpc_sample_t       fifo_in;
    acpc_sample_t       fifo_out;
    logic               fifo_in_ready;
    logic               fifo_out_valid;
    logic               fifo_pop;
    logic [CW-1:0]      fifo_count;

    function automatic logic [DATA_W-1:0] acpc_sat(input logic signed [WIDE_W-1:0] v);
        if (v[WIDE_W-1:DATA_W-1] != {(WIDE_W-DATA_W+1){v[WIDE_W-1]}}) begin
            return v[WIDE_W-1] ? SAT_NEG : SAT_POS;
        end
        return v[DATA_W-1:0];
    endfunction : acpc_sat

    // APB decode
    assign access   = psel_in & penable_in;
    assign load     = access & ~pready_reg;
    assign done     = access & pready_reg;
    assign hit_cfg  = (paddr_in == ADDR_GLOBAL_CFG);
    assign hit_stat = (paddr_in == ADDR_STATUS);
    assign hit_data = (paddr_in == ADDR_DATA);
    assign ch_sel   = paddr_in[4:2];
    assign ch_idx   = 2'(paddr_in[7:5] - CH_BLOCK_FIRST);
    assign hit_ch   = (paddr_in[7:5] >= CH_BLOCK_FIRST) && (paddr_in[7:5] <= CH_BLOCK_LAST)
                      && (ch_sel <= CH_REG_GAIN_LO) && (paddr_in[1:0] == 2'b00);
    assign mapped   = hit_cfg | hit_stat | hit_data | hit_ch;
    assign fifo_pop = load & ~pwrite_in & hit_data & fifo_out_valid;

    always_comb begin
        rd_mux = 32'h0;
        if (hit_cfg) begin
            rd_mux[OSR_CODE_W-1:0] = osr_code_reg;
        end else if (hit_stat) begin
            rd_mux[0] = fifo_out_valid;
            rd_mux[STAT_CNT_LSB +: CW] = fifo_count;
            rd_mux[STAT_PEND_LSB +: NUM_CH] = pend_vec;
        end else if (hit_data) begin
            if (fifo_out_valid) begin
                rd_mux[DATA_CH_LSB +: 2] = fifo_out.channel;
                rd_mux[DATA_W-1:0] = fifo_out.data;
            end
        end else if (hit_ch) begin
            unique case (ch_sel)
                CH_REG_CONFIG: begin
                    rd_mux[CFG_SEL_LSB +: 2] = cfg_reg[ch_idx].input_select;
                    rd_mux[CFG_PHASE_LSB +: PHASE_W] = cfg_reg[ch_idx].sample_phase_offset;
                end
                CH_REG_OFF_UP:  rd_mux[UPPER_W-1:0] = offset_reg[ch_idx][DATA_W-1:LOWER_W];
                CH_REG_OFF_LO:  rd_mux[LOWER_W-1:0] = offset_reg[ch_idx][LOWER_W-1:0];
                CH_REG_GAIN_UP: rd_mux[UPPER_W-1:0] = gain_reg[ch_idx][DATA_W-1:LOWER_W];
                default:        rd_mux[LOWER_W-1:0] = gain_reg[ch_idx][LOWER_W-1:0];
            endcase
        end
    end

    // One wait state, read data and error registered
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0;
        end else begin
            pready_reg  <= load;
            pslverr_reg <= load & ~mapped;
            if (load) begin
                prdata_reg <= pwrite_in ? 32'h0 : rd_mux;
            end
        end
    end

    // Configuration registers, all restored by reset
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            osr_code_reg <= OSR_CODE_RESET;
            for (int i = 0; i < NUM_CH; i++) begin
                cfg_reg[i]    <= '{sample_phase_offset: '0, input_select: ACPC_SEL_NORMAL};
                offset_reg[i] <= OFFSET_RESET;
                gain_reg[i]   <= GAIN_RESET;
            end
        end else if (done && pwrite_in) begin
            if (hit_cfg) begin
                osr_code_reg <= (pwdata_in[OSR_CODE_W-1:0] > OSR_CODE_MAX) ? OSR_CODE_MAX
                                : pwdata_in[OSR_CODE_W-1:0];
            end else if (hit_ch) begin
                unique case (ch_sel)
                    CH_REG_CONFIG: begin
                        cfg_reg[ch_idx].input_select <=
                            acpc_input_sel_t'(pwdata_in[CFG_SEL_LSB +: 2]);
                        cfg_reg[ch_idx].sample_phase_offset <=
                            pwdata_in[CFG_PHASE_LSB +: PHASE_W];
                    end
                    CH_REG_OFF_UP:
                        offset_reg[ch_idx][DATA_W-1:LOWER_W] <= pwdata_in[UPPER_W-1:0];
                    CH_REG_OFF_LO:
                        offset_reg[ch_idx][LOWER_W-1:0] <= pwdata_in[LOWER_W-1:0];
                    CH_REG_GAIN_UP:
                        gain_reg[ch_idx][DATA_W-1:LOWER_W] <= pwdata_in[UPPER_W-1:0];
                    default:
                        gain_reg[ch_idx][LOWER_W-1:0] <= pwdata_in[LOWER_W-1:0];
                endcase
            end
        end
    end

    // Shared test level stream, fixed fraction of full scale before offset and gain correction
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            test_acc_reg <= 5'h00;
            test_bit_reg <= 1'b0;
        end else if ({1'b0, test_acc_reg} + {1'b0, TEST_STEP} >= {1'b0, TEST_MOD}) begin
            test_acc_reg <= 5'(test_acc_reg + TEST_STEP - TEST_MOD);
            test_bit_reg <= 1'b1;
        end else begin
            test_acc_reg <= 5'(test_acc_reg + TEST_STEP);
            test_bit_reg <= 1'b0;
        end
    end

    // Common modulator count, the zero-phase reference for all windows
    assign osr_last   = CNT_W'((15'h0001 << (osr_code_reg + OSR_LOG2_MIN)) - 15'h0001);
    assign frac_shift = 5'(GAIN_FRAC_BITS - (osr_code_reg + OSR_LOG2_MIN));
    assign phase_hi   = (osr_code_reg >= OSR_CODE_CAP) ? $signed(PHASE_HALF_CAP - 11'h001)
                        : $signed(11'((PHASE_HALF_MIN << osr_code_reg) - 11'h001));
    assign phase_lo   = -phase_hi - 11'sh001;

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            // First window after reset spans a full ratio
            mod_count_reg <= CNT_W'(1);
        end else begin
            mod_count_reg <= (mod_count_reg >= osr_last) ? '0 : mod_count_reg + CNT_W'(1);
        end
    end

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        logic               s1_reg;
        logic               s2_reg;
        logic               s3_reg;
        logic               bit_reg;
        logic signed [ACC_W-1:0]   acc_reg;
        logic signed [PHASE_W-1:0] phase_act_reg;
        logic               pend_reg;
        logic [DATA_W-1:0]  res_reg;
        logic signed [10:0] ph_req;
        logic signed [10:0] ph_clip;
        logic [CNT_W-1:0]   target;
        logic               bnd;
        logic signed [1:0]  samp;
        logic signed [ACC_W-1:0]  sum;
        logic [DATA_W-1:0]  raw;
        logic signed [WIDE_W-1:0] diff;
        logic signed [WIDE_W-1:0] prod;
        logic [DATA_W-1:0]  corr;

        // Pin synchroniser, a change counts once stages two and three agree
        always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
                s1_reg  <= 1'b0;
                s2_reg  <= 1'b0;
                s3_reg  <= 1'b0;
                bit_reg <= 1'b0;
            end else begin
                s1_reg <= mod_bit_in[c];
                s2_reg <= s1_reg;
                s3_reg <= s2_reg;
                if (s2_reg == s3_reg) begin
                    bit_reg <= s3_reg;
                end
            end
        end

        always_comb begin
            samp = 2'sb00;
            unique case (cfg_reg[c].input_select)
                ACPC_SEL_NORMAL:   samp = bit_reg ? 2'sb01 : 2'sb11;
                ACPC_SEL_SHORT:    samp = 2'sb00;
                ACPC_SEL_TEST_POS: samp = test_bit_reg ? 2'sb01 : 2'sb11;
                ACPC_SEL_TEST_NEG: samp = test_bit_reg ? 2'sb11 : 2'sb01;
            endcase
        end

        // Clip the requested phase against the current ratio
        assign ph_req  = 11'($signed(cfg_reg[c].sample_phase_offset));
        assign ph_clip = (ph_req > phase_hi) ? phase_hi
                         : (ph_req < phase_lo) ? phase_lo : ph_req;
        // Window ends where the count meets the active phase, modulo the ratio
        assign target  = CNT_W'($signed(phase_act_reg)) & osr_last;
        assign bnd     = (mod_count_reg == target);

        assign sum  = acc_reg + ACC_W'(samp);
        assign raw  = acpc_sat(WIDE_W'(sum) <<< frac_shift);
        assign diff = WIDE_W'($signed(raw)) - WIDE_W'($signed(offset_reg[c]));
        assign prod = diff * $signed({28'h0, gain_reg[c]});
        assign corr = acpc_sat(prod >>> GAIN_FRAC_BITS);

        always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
                acc_reg       <= '0;
                phase_act_reg <= '0;
            end else if (bnd) begin
                acc_reg       <= '0;
                phase_act_reg <= PHASE_W'(ph_clip);
            end else begin
                acc_reg <= sum;
            end
        end

        // New result wins over a same-cycle hand-off to the FIFO
        always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
                pend_reg <= 1'b0;
                res_reg  <= '0;
            end else if (bnd) begin
                pend_reg <= 1'b1;
                res_reg  <= corr;
            end else if (push_oh[c]) begin
                pend_reg <= 1'b0;
            end
        end

        assign pend_vec[c] = pend_reg;
        assign res_vec[c]  = res_reg;
    end

    // Lowest pending channel goes to the FIFO first
    always_comb begin
        push_oh = '0;
        fifo_in = '{channel: 2'b00, data: '0};
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (pend_vec[i]) begin
                push_oh = '0;
                push_oh[i] = fifo_in_ready;
                fifo_in = '{channel: 2'(i), data: res_vec[i]};
            end
        end
    end

    acpc_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_D)
    ) u_fifo (
        .ref_clk_in    (ref_clk_in),
        .reset_n_in    (reset_n_in),
        .in_valid_in   (|pend_vec),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (fifo_in),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (fifo_pop),
        .out_data_out  (fifo_out),
        .count_out     (fifo_count)
    );

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ready_n_reg <= 1'b1;
        end else begin
            ready_n_reg <= ~fifo_out_valid;
        end
    end

    assign prdata_out             = prdata_reg;
    assign pready_out             = pready_reg;
    assign pslverr_out            = pslverr_reg;
    assign conversion_ready_n_out = ready_n_reg;
endmodule : acpc_top
`default_nettype wire

//--- tb/acpc_mod_src.sv
// Modulator bit source standing in for the four analog front ends.
// Assumes the bench sets a constant level per channel; bits change after a clock edge.
`default_nettype none
module acpc_mod_src
    import acpc_pkg::*;
(
    input  wire logic              ref_clk_in,
    input  wire logic [NUM_CH-1:0] level_in,
    output logic      [NUM_CH-1:0] mod_bit_out
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge ref_clk_in) mod_bit_out <= level_in;
endmodule : acpc_mod_src
`default_nettype wire

//--- tb/acpc_top_asserts.sv
// Checker for the register bus side of the channel phase and calibration block.
// Assumes one clock domain and the top module's ports only; bound below.
`default_nettype none
module acpc_top_chk
    import acpc_pkg::*;
(
    input wire logic              ref_clk_in,
    input wire logic              reset_n_in,
    input wire logic              psel_in,
    input wire logic              penable_in,
    input wire logic              pwrite_in,
    input wire logic [7:0]        paddr_in,
    input wire logic [31:0]       pwdata_in,
    input wire logic [31:0]       prdata_out,
    input wire logic              pready_out,
    input wire logic              pslverr_out,
    input wire logic [NUM_CH-1:0] mod_bit_in,
    input wire logic              conversion_ready_n_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    logic mapped;
    // Global block holds three words; channel blocks one to four hold five each
    assign mapped = (paddr_in[7:5] == 3'h0) ? (paddr_in[4:2] < 3'h3)
                  : (paddr_in[7:5] <= CH_BLOCK_LAST && paddr_in[4:2] <= CH_REG_GAIN_LO);
    property p_one_wait;
        psel_in && !penable_in ##1 psel_in && penable_in |=> pready_out;
    endproperty
    property p_ready_pulse;
        pready_out |=> !pready_out;
    endproperty
    property p_idle_quiet;
        !psel_in |=> !pready_out && !pslverr_out;
    endproperty
    property p_decode;
        pready_out && paddr_in[1:0] == 2'h0 |-> pslverr_out == !mapped;
    endproperty
    property p_err_zero;
        pslverr_out |-> pready_out && prdata_out == 32'h0;
    endproperty
    property p_write_zero;
        pready_out && pwrite_in |-> prdata_out == 32'h0;
    endproperty
    property p_status_rsvd;
        pready_out && !pwrite_in && paddr_in == ADDR_STATUS |-> prdata_out[31:12] == 20'h0;
    endproperty
    property p_osr_range;
        pready_out && !pwrite_in && paddr_in == ADDR_GLOBAL_CFG
            |-> prdata_out[3:0] <= OSR_CODE_MAX && prdata_out[31:4] == 28'h0;
    endproperty
    property p_gain_lower;
        pready_out && !pwrite_in && paddr_in[7:5] != 3'h0 && paddr_in[4:2] == CH_REG_GAIN_LO
            |-> prdata_out[31:8] == 24'h0;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("ready not after one wait");
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
    a_idle_quiet: assert property (p_idle_quiet) else $error("answer without request");
    a_decode: assert property (p_decode) else $error("error flag disagrees with map");
    a_err_zero: assert property (p_err_zero) else $error("error with data or alone");
    a_write_zero: assert property (p_write_zero) else $error("write returned data");
    a_status_rsvd: assert property (p_status_rsvd) else $error("status spare bits set");
    a_osr_range: assert property (p_osr_range) else $error("ratio code out of range");
    a_gain_lower: assert property (p_gain_lower) else $error("gain lower too wide");
    c_error: cover property (pslverr_out);
    c_write: cover property (pready_out && pwrite_in);
    c_result: cover property ($fell(conversion_ready_n_out));
endmodule : acpc_top_chk
bind acpc_top acpc_top_chk u_chk (.ref_clk_in, .reset_n_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .mod_bit_in, .conversion_ready_n_out);
`default_nettype wire

//--- tb/acpc_top_test.sv
// Bench for acpc_top: register reset values, map errors, corrected conversions.
// Assumes a 40 MHz clock and constant-level modulator streams.
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, (a), (e)); end end
module acpc_top_test
    import acpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk     = 1'b0;
    logic              reset_n = 1'b0;
    logic              psel    = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite  = 1'b0;
    logic [7:0]        paddr   = 8'h00;
    logic [31:0]       pwdata  = 32'h0;
    logic [NUM_CH-1:0] level   = '0;
    logic [31:0]       prdata, rd;
    logic              pready, pslverr, rdy_n, er;
    logic [NUM_CH-1:0] mod_bit;
    logic [23:0]       got [NUM_CH];
    int                err_count = 0;
    int                checked   = 0;
    always #12.5 clk = ~clk;
    acpc_top u_dut (.ref_clk_in(clk), .reset_n_in(reset_n), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .mod_bit_in(mod_bit), .conversion_ready_n_out(rdy_n));
    acpc_mod_src u_src (.ref_clk_in(clk), .level_in(level), .mod_bit_out(mod_bit));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            err_count++;
            stop_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
        `CHK(er, 1'b0)
    endtask : rchk
    task automatic conv();
        int n;
        repeat (200) @(posedge clk);
        for (n = 0; n < 40; n++) begin
            apb(1'b0, ADDR_STATUS, 32'h0);
            if (rd[11:0] == 12'h0) break;
            apb(1'b0, ADDR_DATA, 32'h0);
        end
        n = 0;
        while (rdy_n !== 1'b0 && n < 300) begin
            @(posedge clk);
            n++;
        end
        if (n == 300) begin
            err_count++;
            stop_test();
        end
        repeat (8) @(posedge clk);
        for (n = 0; n < NUM_CH; n++) begin
            apb(1'b0, ADDR_DATA, 32'h0);
            `CHK(rd[25:24], 2'(n))
            got[n] = rd[23:0];
        end
    endtask : conv
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        rchk(ADDR_GLOBAL_CFG, 32'h4);
        for (int c = 1; c <= NUM_CH; c++) begin
            rchk(8'(32 * c), 32'h0);
            rchk(8'(32 * c + 4), 32'h0);
            rchk(8'(32 * c + 8), 32'h0);
            rchk(8'(32 * c + 12), 32'h8000);
            rchk(8'(32 * c + 16), 32'h0);
        end
        $display("test reset values done");
        apb(1'b0, 8'hC0, 32'h0);
        `CHK(er, 1'b1)
        `CHK(rd, 32'h0)
        apb(1'b1, 8'h34, 32'h1);
        `CHK(er, 1'b1)
        $display("test unmapped done");
        level <= 4'b0001;
        apb(1'b1, ADDR_GLOBAL_CFG, 32'hF);
        rchk(ADDR_GLOBAL_CFG, 32'h8);
        apb(1'b1, ADDR_GLOBAL_CFG, 32'h0);
        apb(1'b1, 8'h60, 32'h1);
        apb(1'b1, 8'h64, 32'h0001);
        apb(1'b1, 8'h6C, 32'h4000);
        apb(1'b1, 8'h80, 32'h1);
        rchk(8'h6C, 32'h4000);
        conv();
        `CHK(got[0], 24'h7FFFFF)
        `CHK(got[1], 24'h800000)
        `CHK(got[2], 24'hFFFF80)
        `CHK(got[3], 24'h000000)
        $display("test correction done");
        level <= 4'b0100;
        apb(1'b1, 8'h20, 32'h2);
        apb(1'b1, 8'h40, 32'h3);
        apb(1'b1, 8'h60, 32'h0);
        apb(1'b1, 8'h80, 32'h41);
        rchk(8'h80, 32'h41);
        conv();
        `CHK(got[0] == 24'h100000 || got[0] == 24'h140000, 1'b1)
        `CHK(got[1], 24'(-got[0]))
        `CHK(got[2], 24'h3FFF7F)
        `CHK(got[3], 24'h000000)
        $display("test levels done");
        reset_n <= 1'b0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        rchk(ADDR_GLOBAL_CFG, 32'h4);
        `CHK(rdy_n, 1'b1)
        rchk(ADDR_STATUS, 32'h0);
        rchk(8'h20, 32'h0);
        rchk(8'h64, 32'h0);
        rchk(8'h6C, 32'h8000);
        apb(1'b1, 8'h64, 32'h0001);
        rchk(8'h64, 32'h1);
        $display("test second reset done");
        stop_test();
    end
endmodule : acpc_top_test
`default_nettype wire
